//--- include/pesc_pkg.sv
// Constants for the event, mask, status and control register group.
// Assumes a single 25 MHz clock and a byte-wide register port fed by the serial bus engine.
package pesc_pkg;

    localparam int CLK_PERIOD_NS = 40;
    // Settling time allowed to the backup cell comparators
    localparam int BACKUP_SETTLE_NS = 2000;
    localparam int BACKUP_SETTLE_CYC = (BACKUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(BACKUP_SETTLE_CYC + 1);

    localparam logic [7:0] OFS_SYSTEM_EVENT_FLAGS = 8'h01;
    localparam logic [7:0] OFS_SWITCH_EVENT_FLAGS = 8'h02;
    localparam logic [7:0] OFS_SYSTEM_EVENT_MASK = 8'h03;
    localparam logic [7:0] OFS_SWITCH_EVENT_MASK = 8'h04;
    localparam logic [7:0] OFS_DEVICE_STATUS = 8'h05;
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h06;

    localparam int EVT_W = 6;
    localparam logic [5:0] RST_EVENT_FLAGS = 6'h00;
    localparam logic [5:0] RST_EVENT_MASK = 6'h00;
    localparam logic [1:0] RST_BACKUP_LEVEL = 2'h0;

    // Switch event bits
    localparam int SW3_FAULT_BIT = 5;
    localparam int SW2_FAULT_BIT = 4;
    localparam int SW1_FAULT_BIT = 3;
    localparam int SW3_LIMIT_BIT = 2;
    localparam int SW2_LIMIT_BIT = 1;
    localparam int SW1_LIMIT_BIT = 0;

    // System event bits
    localparam int PROG_VOLTAGE_BIT = 5;
    localparam int MAINS_CHANGE_BIT = 4;
    localparam int BUTTON_CHANGE_BIT = 3;
    localparam int OVERTEMP_BIT = 2;
    localparam int BACKUP_DONE_BIT = 1;
    localparam int DEFAULTS_WRITTEN_BIT = 0;

    // Status bits
    localparam int STAT_SEAL_BIT = 7;
    localparam int STAT_MODIFIED_BIT = 6;
    localparam int STAT_MAINS_BIT = 5;
    localparam int STAT_BUTTON_BIT = 4;
    localparam int STAT_STATE_LSB = 2;
    localparam int STAT_LEVEL_LSB = 0;

    // Control bits
    localparam int CTRL_PFSD_BIT = 1;
    localparam int CTRL_MEASURE_BIT = 0;

    // Power state machine encoding seen in the status field
    localparam logic [1:0] PSM_TRANSITIONAL = 2'h0;
    localparam logic [1:0] PSM_AWAIT_POWER_ENABLE = 2'h1;
    localparam logic [1:0] PSM_ACTIVE = 2'h2;
    localparam logic [1:0] PSM_SUSPEND = 2'h3;

    typedef enum logic [1:0] {MEAS_IDLE, MEAS_SETTLE, MEAS_DONE} pesc_meas_t;

    // An event reaches the interrupt when its flag is set and its mask is 0
    function automatic logic pesc_pending(input logic [5:0] flags, input logic [5:0] mask);
        pesc_pending = |(flags & ~mask);
    endfunction : pesc_pending

endpackage : pesc_pkg

//--- design/pesc_event_flags.sv
// Sticky event flag bank, cleared by a read of its register.
// Assumes set and clear are synchronous to clk; a set in the clearing cycle survives.
`timescale 1ns/100ps
module pesc_event_flags import pesc_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [EVT_W-1:0] set,
    input wire logic clr,
    output logic [EVT_W-1:0] flags_q
);
    logic [EVT_W-1:0] flags_d;

    always_comb begin
        flags_d = clr ? set : (flags_q | set);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= RST_EVENT_FLAGS;
        end else if (clk_en) begin
            flags_q <= flags_d;
        end
    end

    a_set_beats_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && clr) |=> ((flags_q & $past(set)) == $past(set)))
        else $error("Event lost while its flag was cleared");

endmodule : pesc_event_flags

//--- design/pesc_backup_measure.sv
// Backup cell level acquisition: enables comparators, waits to settle, latches the band.
// Assumes comparator outputs are synchronous and valid after the settle count.
`timescale 1ns/100ps
module pesc_backup_measure import pesc_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [1:0] cmp_level,
    output logic cmp_en,
    output logic busy,
    output logic done,
    output logic [1:0] level_q,
    output logic valid_q
);
    pesc_meas_t state_q, state_d;
    logic [SETTLE_W-1:0] cnt_q, cnt_d;
    logic [1:0] level_d;
    logic valid_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        level_d = level_q;
        valid_d = valid_q;
        unique case (state_q)
            MEAS_IDLE: begin
                if (start) begin
                    state_d = MEAS_SETTLE;
                    cnt_d = SETTLE_W'(BACKUP_SETTLE_CYC - 1);
                end
            end
            MEAS_SETTLE: begin
                if (cnt_q == '0) begin
                    state_d = MEAS_DONE;
                    level_d = cmp_level;
                    valid_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            MEAS_DONE: begin
                state_d = MEAS_IDLE;
            end
            default: begin
                state_d = MEAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= MEAS_IDLE;
            cnt_q <= '0;
            level_q <= RST_BACKUP_LEVEL;
            valid_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            level_q <= level_d;
            valid_q <= valid_d;
        end
    end

    assign cmp_en = (state_q == MEAS_SETTLE);
    assign busy = (state_q != MEAS_IDLE);
    assign done = (state_q == MEAS_DONE);

    a_done_has_result: assert property (@(posedge clk) disable iff (!arst_n)
        (done && $past(clk_en)) |-> (valid_q && level_q == $past(cmp_level)))
        else $error("Acquisition done without its result latched");

endmodule : pesc_backup_measure

//--- design/pesc_event_ctrl.sv
// Event flags, masks, status and control registers with the active-low interrupt.
// Assumes a byte register port driven by the serial bus engine, all inputs synchronous to clk.
`timescale 1ns/100ps
//Contract
//- Switch three overtemperature sets switch flag bit 5.
//- Switch two overtemperature or input undervoltage sets switch flag bit 4.
//- Switch one overtemperature sets switch flag bit 3.
//- Bits 2..0 show switches three..one current limiting.
//- Mask 0 lets event pull interrupt low; mask 1 blocks it.
//- Masks gate only the interrupt; flags record regardless.
//- System mask bits 5..0 in documented order, bits 7..6 zero.
//- Switch mask: fault masks bits 5..3, limit masks 2..0, top zero.
//- Status bit 7 shows the freshness seal broken.
//- Status bit 6 shows defaults changed from factory settings.
//- Status bit 5 is inverted mains detect pin.
//- Status bit 4 is inverted push button pin.
//- Status bits 3..2 encode power state machine state.
//- Backup level field encodes four voltage bands.
//- Control bit 1 set: power fail trip requests full shutdown.
//- Writing 1 to control bit 0 starts acquisition, then self clears.
//- Mains detect pin change in either direction raises an event.
//- Push button change in either direction raises an event.
//- Acquisition done event once comparator result is in status.
module pesc_event_ctrl import pesc_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic switch_three_overtemp,
    input wire logic switch_two_overtemp,
    input wire logic switch_two_undervolt,
    input wire logic switch_one_overtemp,
    input wire logic switch_three_limiting,
    input wire logic switch_two_limiting,
    input wire logic switch_one_limiting,
    input wire logic prog_voltage_low,
    input wire logic overtemp_warning,
    input wire logic defaults_written_pulse,
    input wire logic mains_detect_pin,
    input wire logic push_button_pin,
    input wire logic power_fail_out_n,
    input wire logic freshness_seal_broken,
    input wire logic defaults_modified,
    input wire logic [1:0] power_state,
    input wire logic [1:0] backup_cmp_level,
    output logic backup_cmp_en,
    output logic backup_level_valid,
    output logic shutdown_req,
    output logic irq_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Pin history for change detection
    logic mains_prev_q, mains_prev_d;
    logic button_prev_q, button_prev_d;
    logic prev_valid_q, prev_valid_d;
    logic mains_change, button_change;

    // Register state
    logic [EVT_W-1:0] system_event_mask_q, system_event_mask_d;
    logic [EVT_W-1:0] switch_event_mask_q, switch_event_mask_d;
    logic powerfail_shutdown_en_q, powerfail_shutdown_en_d;
    logic backup_measure_start_q, backup_measure_start_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_n_q, irq_n_d;
    logic shutdown_q, shutdown_d;

    // Decodes and flag banks
    logic wr_sys_mask, wr_sw_mask, wr_control;
    logic rd_sys_flags, rd_sw_flags;
    logic [EVT_W-1:0] system_event_set, switch_event_set;
    logic [EVT_W-1:0] system_event_flags, switch_event_flags;
    logic [7:0] device_status;
    logic meas_busy, meas_done;
    logic [1:0] backup_cell_level;

    always_comb begin
        wr_sys_mask = reg_wr && (reg_addr == OFS_SYSTEM_EVENT_MASK);
        wr_sw_mask = reg_wr && (reg_addr == OFS_SWITCH_EVENT_MASK);
        wr_control = reg_wr && (reg_addr == OFS_POWER_CONTROL);
        rd_sys_flags = reg_rd && (reg_addr == OFS_SYSTEM_EVENT_FLAGS);
        rd_sw_flags = reg_rd && (reg_addr == OFS_SWITCH_EVENT_FLAGS);
    end

    // First sample after reset only primes the history, so a pin held low is no change
    always_comb begin
        mains_prev_d = mains_detect_pin;
        button_prev_d = push_button_pin;
        prev_valid_d = 1'b1;
        mains_change = prev_valid_q && (mains_detect_pin != mains_prev_q);
        button_change = prev_valid_q && (push_button_pin != button_prev_q);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mains_prev_q <= 1'b1;
            button_prev_q <= 1'b1;
            prev_valid_q <= 1'b0;
        end else if (clk_en) begin
            mains_prev_q <= mains_prev_d;
            button_prev_q <= button_prev_d;
            prev_valid_q <= prev_valid_d;
        end
    end

    // Fault and limit conditions are levels; a flag keeps setting while its cause lasts
    always_comb begin
        switch_event_set = '0;
        switch_event_set[SW3_FAULT_BIT] = switch_three_overtemp;
        switch_event_set[SW2_FAULT_BIT] = switch_two_overtemp || switch_two_undervolt;
        switch_event_set[SW1_FAULT_BIT] = switch_one_overtemp;
        switch_event_set[SW3_LIMIT_BIT] = switch_three_limiting;
        switch_event_set[SW2_LIMIT_BIT] = switch_two_limiting;
        switch_event_set[SW1_LIMIT_BIT] = switch_one_limiting;
        system_event_set = '0;
        system_event_set[PROG_VOLTAGE_BIT] = prog_voltage_low;
        system_event_set[MAINS_CHANGE_BIT] = mains_change;
        system_event_set[BUTTON_CHANGE_BIT] = button_change;
        system_event_set[OVERTEMP_BIT] = overtemp_warning;
        system_event_set[BACKUP_DONE_BIT] = meas_done;
        system_event_set[DEFAULTS_WRITTEN_BIT] = defaults_written_pulse;
    end

    // Masks are not applied here, so monitoring runs whatever software has masked
    pesc_event_flags u_switch_flags (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .set(switch_event_set),
        .clr(rd_sw_flags),
        .flags_q(switch_event_flags)
    );

    pesc_event_flags u_system_flags (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .set(system_event_set),
        .clr(rd_sys_flags),
        .flags_q(system_event_flags)
    );

    pesc_backup_measure u_backup (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .start(backup_measure_start_q),
        .cmp_level(backup_cmp_level),
        .cmp_en(backup_cmp_en),
        .busy(meas_busy),
        .done(meas_done),
        .level_q(backup_cell_level),
        .valid_q(backup_level_valid)
    );

    always_comb begin
        device_status = '0;
        device_status[STAT_SEAL_BIT] = freshness_seal_broken;
        device_status[STAT_MODIFIED_BIT] = defaults_modified;
        device_status[STAT_MAINS_BIT] = ~mains_detect_pin;
        device_status[STAT_BUTTON_BIT] = ~push_button_pin;
        device_status[STAT_STATE_LSB +: 2] = power_state;
        device_status[STAT_LEVEL_LSB +: 2] = backup_cell_level;
    end

    // Register writes, read data and the control side effects
    always_comb begin
        system_event_mask_d = system_event_mask_q;
        switch_event_mask_d = switch_event_mask_q;
        powerfail_shutdown_en_d = powerfail_shutdown_en_q;
        backup_measure_start_d = backup_measure_start_q;
        rdata_d = rdata_q;
        if (wr_sys_mask) begin
            system_event_mask_d = reg_wdata[EVT_W-1:0];
        end
        if (wr_sw_mask) begin
            switch_event_mask_d = reg_wdata[EVT_W-1:0];
        end
        if (meas_done) begin
            backup_measure_start_d = 1'b0;
        end
        // A new start written in the done cycle is kept rather than lost
        if (wr_control) begin
            powerfail_shutdown_en_d = reg_wdata[CTRL_PFSD_BIT];
            if (reg_wdata[CTRL_MEASURE_BIT]) begin
                backup_measure_start_d = 1'b1;
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_SYSTEM_EVENT_FLAGS: rdata_d = {2'b00, system_event_flags};
                OFS_SWITCH_EVENT_FLAGS: rdata_d = {2'b00, switch_event_flags};
                OFS_SYSTEM_EVENT_MASK: rdata_d = {2'b00, system_event_mask_q};
                OFS_SWITCH_EVENT_MASK: rdata_d = {2'b00, switch_event_mask_q};
                OFS_DEVICE_STATUS: rdata_d = device_status;
                OFS_POWER_CONTROL: rdata_d = {6'h00, powerfail_shutdown_en_q, backup_measure_start_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            system_event_mask_q <= RST_EVENT_MASK;
            switch_event_mask_q <= RST_EVENT_MASK;
            powerfail_shutdown_en_q <= 1'b0;
            backup_measure_start_q <= 1'b0;
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            system_event_mask_q <= system_event_mask_d;
            switch_event_mask_q <= switch_event_mask_d;
            powerfail_shutdown_en_q <= powerfail_shutdown_en_d;
            backup_measure_start_q <= backup_measure_start_d;
            rdata_q <= rdata_d;
        end
    end

    // Interrupt and shutdown outputs are registered to keep them glitch free on the pins
    always_comb begin
        irq_n_d = ~(pesc_pending(system_event_flags, system_event_mask_q)
            || pesc_pending(switch_event_flags, switch_event_mask_q));
        shutdown_d = powerfail_shutdown_en_q && !power_fail_out_n;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n_q <= 1'b1;
            shutdown_q <= 1'b0;
        end else if (clk_en) begin
            irq_n_q <= irq_n_d;
            shutdown_q <= shutdown_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_out_n = irq_n_q;
    assign shutdown_req = shutdown_q;

    a_irq_pending_low: assert property (
        (clk_en && (|(switch_event_flags & ~switch_event_mask_q))) |=> !irq_out_n)
        else $error("Unmasked switch flag did not pull the interrupt low");

    a_irq_masked_high: assert property (
        (clk_en && (&system_event_mask_q) && (&switch_event_mask_q)) |=> irq_out_n)
        else $error("Interrupt asserted with every event masked");

    a_fault_flag_masked: assert property (
        (clk_en && switch_three_overtemp && switch_event_mask_q[SW3_FAULT_BIT])
        |=> switch_event_flags[SW3_FAULT_BIT])
        else $error("Masked switch three fault was not recorded");

    a_limit_flag_set: assert property (
        (clk_en && switch_one_limiting) |=> switch_event_flags[SW1_LIMIT_BIT])
        else $error("Switch one limiting not shown in its flag");

    sequence s_mains_toggle;
        clk_en && prev_valid_q && (mains_detect_pin != mains_prev_q);
    endsequence

    a_mains_change_flag: assert property (
        s_mains_toggle |=> system_event_flags[MAINS_CHANGE_BIT])
        else $error("Mains pin change raised no event");

    a_button_change_flag: assert property (
        (clk_en && prev_valid_q && (push_button_pin != button_prev_q))
        |=> system_event_flags[BUTTON_CHANGE_BIT])
        else $error("Button pin change raised no event");

    a_status_pins_inverted: assert property (
        (clk_en && reg_rd && reg_addr == OFS_DEVICE_STATUS)
        |=> (reg_rdata[STAT_MAINS_BIT] == !$past(mains_detect_pin)
        && reg_rdata[STAT_BUTTON_BIT] == !$past(push_button_pin)))
        else $error("Status pin bits not inverted pin levels");

    a_shutdown_gated: assert property (
        (clk_en && !power_fail_out_n) |=> (shutdown_req == $past(powerfail_shutdown_en_q)))
        else $error("Shutdown request disagrees with its enable");

    a_reserved_zero: assert property (
        (clk_en && reg_rd && reg_addr == OFS_SWITCH_EVENT_FLAGS) |=> (reg_rdata[7:6] == 2'b00))
        else $error("Reserved flag bits read nonzero");

    sequence s_measure_finish;
        clk_en && meas_done && !wr_control;
    endsequence

    a_start_self_clears: assert property (
        s_measure_finish |=> !backup_measure_start_q ##1 !meas_busy)
        else $error("Acquisition start bit did not clear after completion");

    a_sys_irq_low: assert property (
        (clk_en && (|(system_event_flags & ~system_event_mask_q))) |=> !irq_out_n)
        else $error("Unmasked system flag did not pull the interrupt low");

    a_freeze_holds: assert property (
        !clk_en |=> ($stable(system_event_mask_q) && $stable(switch_event_mask_q)
        && $stable(reg_rdata) && $stable(irq_out_n)))
        else $error("State moved while the clock enable was low");

    a_sys_mask_write: assert property (
        (clk_en && wr_sys_mask) |=> ({2'b00, system_event_mask_q} == ($past(reg_wdata) & 8'h3F)))
        else $error("System mask write not stored");

    a_sw_mask_write: assert property (
        (clk_en && wr_sw_mask) |=> ({2'b00, switch_event_mask_q} == ($past(reg_wdata) & 8'h3F)))
        else $error("Switch mask write not stored");

    a_flags_read_only: assert property (
        (clk_en && reg_wr && !reg_rd && reg_addr == OFS_SWITCH_EVENT_FLAGS && !(|switch_event_set))
        |=> $stable(switch_event_flags))
        else $error("Write changed the switch flags");

    a_start_write: assert property (
        (clk_en && wr_control && reg_wdata[CTRL_MEASURE_BIT]) |=> backup_measure_start_q)
        else $error("Acquisition start write not taken");

    a_done_flag_set: assert property (
        (clk_en && meas_done) |=> system_event_flags[BACKUP_DONE_BIT])
        else $error("Acquisition done raised no event");

    a_pfsd_write: assert property (
        (clk_en && wr_control && reg_wdata[CTRL_PFSD_BIT]) |=> powerfail_shutdown_en_q)
        else $error("Shutdown enable write not taken");

    a_shutdown_idle: assert property (
        (clk_en && power_fail_out_n) |=> !shutdown_req)
        else $error("Shutdown requested without a power fail");

    a_seal_status: assert property (
        (clk_en && reg_rd && reg_addr == OFS_DEVICE_STATUS)
        |=> ({reg_rdata[STAT_SEAL_BIT], reg_rdata[STAT_MODIFIED_BIT]}
        == {$past(freshness_seal_broken), $past(defaults_modified)}))
        else $error("Seal and defaults status bits wrong");

endmodule : pesc_event_ctrl

//--- bench/pesc_host_model.sv
// Host side of the register byte port: single-byte writes and reads.
// Assumes the design takes a request on the rising edge; this model drives on the falling edge.
`timescale 1ns/100ps
module pesc_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // Inverted stale data exposes a write that samples late
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : pesc_host_model

//--- bench/tb_pmic_event_status_control.sv
// Self-checking bench for the event, mask, status and control register group.
// Assumes the host model drives the byte port; other inputs change on the falling edge.
`timescale 1ns/100ps
module tb_pmic_event_status_control import pesc_pkg::*;;
    logic clk, arst_n, reg_wr, reg_rd, pfo_n, seal, modified, mains, button;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [6:0] cause;
    logic prog_low, overtemp_warning_event, dw_pulse, cmp_en, lvl_valid, shutdown_req, irq_out_n, ce;
    logic [1:0] power_state, cmp_level;
    logic [15:0] lfsr_q;
    int mismatches, samples_checked, lvl_m, n;
    int bt[12] = '{0, 1, 2, 3, 4, 4, 5, 4, 3, 2, 5, 0};
    always #20 clk = ~clk;
    pesc_host_model pesc_host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    pesc_event_ctrl pesc_event_ctrl_inst (.clk(clk), .arst_n(arst_n), .clk_en(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .switch_three_overtemp(cause[6]), .switch_two_overtemp(cause[5]),
        .switch_two_undervolt(cause[4]), .switch_one_overtemp(cause[3]),
        .switch_three_limiting(cause[2]), .switch_two_limiting(cause[1]),
        .switch_one_limiting(cause[0]), .prog_voltage_low(prog_low), .overtemp_warning(overtemp_warning_event),
        .defaults_written_pulse(dw_pulse), .mains_detect_pin(mains), .push_button_pin(button),
        .power_fail_out_n(pfo_n), .freshness_seal_broken(seal), .defaults_modified(modified),
        .power_state(power_state), .backup_cmp_level(cmp_level), .backup_cmp_en(cmp_en),
        .backup_level_valid(lvl_valid), .shutdown_req(shutdown_req), .irq_out_n(irq_out_n));
    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction : rnd
    function automatic logic [7:0] stat_exp();
        return {seal, modified, ~mains, ~button, power_state, 2'(lvl_m)};
    endfunction : stat_exp
    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        pesc_host_model_inst.rd(a, v);
        chk(nm, v, e);
    endtask : rchk
    task automatic wait_en(input logic w);
        n = 0;
        while (cmp_en !== w) begin
            @(negedge clk);
            n++;
            if (n > 200) begin
                mismatches++;
                summarize();
            end
        end
    endtask : wait_en
    // One event: set its mask, fire the cause, then check irq, flag, clear and live status
    task automatic ev(input int k, input logic m);
        logic [7:0] a;
        logic [7:0] r;
        a = (k < 7) ? OFS_SWITCH_EVENT_FLAGS : OFS_SYSTEM_EVENT_FLAGS;
        r = rnd();
        seal = r[0];
        modified = r[1];
        power_state = 2'(k);
        pesc_host_model_inst.wr(a + 8'h02, m ? 8'(1 << bt[k]) : 8'h00);
        @(negedge clk);
        case (k)
            7: mains = ~mains;
            8: button = ~button;
            9: overtemp_warning_event = 1'b1;
            10: prog_low = 1'b1;
            11: dw_pulse = 1'b1;
            default: cause[k] = 1'b1;
        endcase
        @(negedge clk);
        cause = 7'h00;
        overtemp_warning_event = 1'b0;
        prog_low = 1'b0;
        dw_pulse = 1'b0;
        @(negedge clk);
        chk("irq", 8'(irq_out_n), 8'(m));
        rchk(a, 8'(1 << bt[k]), "flags");
        rchk(a, 8'h00, "cleared");
        chk("irq idle", 8'(irq_out_n), 8'h01);
        rchk(OFS_DEVICE_STATUS, stat_exp(), "status");
    endtask : ev
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {cause, prog_low, overtemp_warning_event, dw_pulse, seal, modified, power_state, cmp_level} = '0;
        {mains, button, pfo_n, ce} = 4'hF;
        lfsr_q = 16'hC82A;
        lvl_m = 0;
        mismatches = 0;
        samples_checked = 0;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        chk("irq reset", 8'(irq_out_n), 8'h01);
        chk("valid reset", 8'(lvl_valid), 8'h00);
        chk("cmp_en reset", 8'(cmp_en), 8'h00);
        for (int i = 1; i < 8; i++) if (i != 5) rchk(8'(i), 8'h00, "reset");
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            pesc_host_model_inst.wr(OFS_SYSTEM_EVENT_MASK, d);
            pesc_host_model_inst.wr(OFS_SWITCH_EVENT_MASK, ~d);
            pesc_host_model_inst.wr(OFS_SWITCH_EVENT_FLAGS, d);
            pesc_host_model_inst.wr(OFS_POWER_CONTROL, d & 8'hFE);
            rchk(OFS_SYSTEM_EVENT_MASK, d & 8'h3F, "sys mask");
            rchk(OFS_SWITCH_EVENT_MASK, ~d & 8'h3F, "sw mask");
            rchk(OFS_SWITCH_EVENT_FLAGS, 8'h00, "ro flags");
            rchk(OFS_POWER_CONTROL, d & 8'h02, "control");
        end
        pesc_host_model_inst.wr(OFS_POWER_CONTROL, 8'h00);
        // Everything masked: flags still record while the interrupt stays quiet
        pesc_host_model_inst.wr(OFS_SYSTEM_EVENT_MASK, 8'hFF);
        pesc_host_model_inst.wr(OFS_SWITCH_EVENT_MASK, 8'hFF);
        @(negedge clk);
        cause = 7'h7F;
        {overtemp_warning_event, prog_low, dw_pulse} = 3'h7;
        @(negedge clk);
        cause = 7'h00;
        {overtemp_warning_event, prog_low, dw_pulse} = 3'h0;
        repeat (2) @(negedge clk);
        chk("irq masked", 8'(irq_out_n), 8'h01);
        rchk(OFS_SWITCH_EVENT_FLAGS, 8'h3F, "all sw");
        rchk(OFS_SYSTEM_EVENT_FLAGS, 8'h25, "all sys");
        ce = 1'b0;
        pesc_host_model_inst.wr(OFS_SYSTEM_EVENT_MASK, 8'h15);
        ce = 1'b1;
        rchk(OFS_SYSTEM_EVENT_MASK, 8'h3F, "frozen");
        for (int k = 0; k < 12; k++) begin
            ev(k, 1'b1);
            ev(k, 1'b0);
        end
        // Host starts an acquisition before it trusts the level field
        for (int l = 0; l < 4; l++) begin
            cmp_level = 2'(l);
            pesc_host_model_inst.wr(OFS_POWER_CONTROL, 8'h01);
            rchk(OFS_POWER_CONTROL, 8'h01, "start bit");
            wait_en(1'b1);
            wait_en(1'b0);
            chk("settle", 8'(n >= BACKUP_SETTLE_CYC - 2 && n <= BACKUP_SETTLE_CYC + 2), 8'h01);
            repeat (2) @(negedge clk);
            cmp_level = 2'(~l);
            lvl_m = l;
            chk("valid", 8'(lvl_valid), 8'h01);
            chk("done irq", 8'(irq_out_n), 8'h00);
            rchk(OFS_POWER_CONTROL, 8'h00, "self clear");
            rchk(OFS_SYSTEM_EVENT_FLAGS, 8'(1 << BACKUP_DONE_BIT), "done flag");
            rchk(OFS_DEVICE_STATUS, stat_exp(), "level");
        end
        pfo_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("no shutdown", 8'(shutdown_req), 8'h00);
        pesc_host_model_inst.wr(OFS_POWER_CONTROL, 8'h02);
        @(negedge clk);
        chk("shutdown", 8'(shutdown_req), 8'h01);
        pfo_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("release", 8'(shutdown_req), 8'h00);
        summarize();
    end
endmodule : tb_pmic_event_status_control
